/* hw/vector_select.sv */
// Operation
// R01 - Alternate-table select set uses alternate table; clear uses primary table.
// R02 - Alternate entries sit 0x100 above primary entries, same layout.
// R03 - Reset entry bypasses trap and interrupt vectoring entirely.
// R04 - After reset, registers clear and program counter loads zero.
// R05 - Traps 0-7 at 0x04..0x12 step two; 1-4 osc, address, stack, math.
// R06 - Request number plus eight gives vector; request 0 at 0x14, step two.
// R07 - Requests 0-8: ext0, capture1, compare1, timer1, -, capture2, compare2, timer2, timer3.
// R08 - Requests 9-13, 16, 17, 65 serve SPI, UART, ADC and I2C sources.
// R09 - Other sources at 18,19,20,27,28,29,37,57,62,63,64,77.
// R10 - Timers four/five and fault B exist only per build parameters.
// R11 - Software fills unused alternate table with primary handler addresses.
// R12 - Software points unused entries at a reset-issuing default handler.
// R13 - Each entry holds a 24-bit handler address loaded into the PC.
// R14 - Lower vector number wins among pending requests.
// R15 - Reserved request positions never reach the CPU.
`timescale 1ns/1ps
`include "vector_select_cfg.svh"

module vector_select
  import vector_select_pkg::*;
#(
  parameter bit HAS_TIMER45 = 1'b1,
  parameter bit HAS_FAULT_B = 1'b1
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic resetn, // Async reset, active low
  input wire logic alt_table_select, // 1 = alternate table
  input wire logic trap_osc_fail, // Oscillator failure trap
  input wire logic trap_addr_err, // Address error trap
  input wire logic trap_stack_err, // Stack error trap
  input wire logic trap_math_err, // Math error trap
  input wire logic external_irq_zero, // Request 0
  input wire logic capture_unit_one, // Request 1
  input wire logic compare_unit_one, // Request 2
  input wire logic timer_one, // Request 3
  input wire logic capture_unit_two, // Request 5
  input wire logic compare_unit_two, // Request 6
  input wire logic timer_two, // Request 7
  input wire logic timer_three, // Request 8
  input wire logic spi_error_source, // Request 9
  input wire logic spi_done_source, // Request 10
  input wire logic uart_receive_source, // Request 11
  input wire logic uart_transmit_source, // Request 12
  input wire logic converter_source, // Request 13
  input wire logic i2c_slave_source, // Request 16
  input wire logic i2c_master_source, // Request 17
  input wire logic comparator_source, // Request 18
  input wire logic change_notify_source, // Request 19
  input wire logic external_irq_one, // Request 20
  input wire logic timer_four, // Request 27
  input wire logic timer_five, // Request 28
  input wire logic external_irq_two, // Request 29
  input wire logic capture_unit_three, // Request 37
  input wire logic pwm_period_source, // Request 57
  input wire logic calendar_clock_source, // Request 62
  input wire logic pwm_fault_a_source, // Request 63
  input wire logic pwm_fault_b_source, // Request 64
  input wire logic uart_error_source, // Request 65
  input wire logic charge_time_source, // Request 77
  input wire logic take_vec, // CPU takes pending vector
  input wire logic fetch_valid, // Program memory word valid
  input wire logic [23:0] fetch_data, // Handler address word
  output logic vec_pending_ff, // Request toward CPU
  output logic [6:0] pend_num_ff, // Winning vector number
  output logic pend_trap_ff, // Winner is a trap
  output logic fetch_req_ff, // Entry read request
  output logic [23:0] fetch_addr_ff, // Entry address
  output logic pc_load_ff, // Load program counter
  output logic [23:0] pc_value_ff, // Program counter value
  output logic taken_valid_ff, // Vector taken pulse
  output vec_taken_t taken_ff, // Taken vector details
  output logic busy_ff // Reset entry or fetch running
);

  logic [`NUM_TRAP-1:0] trap_req;
  logic [`NUM_IRQ-1:0] irq_req;
  logic [`NUM_VEC-1:0] all_req;
  vec_choice_t winner;
  logic winner_any;
  vsel_state_t state_ff;
  vsel_state_t nxt_state;
  vec_taken_t nxt_taken;
  logic [23:0] nxt_fetch_addr;
  logic accept;

  // Positions that exist in this build; every other bit is reserved
  function automatic logic [`NUM_VEC-1:0] impl_mask(bit has_t45, bit has_fb);
    logic [`NUM_VEC-1:0] m;
    m = '0;
    // Traps 0, 5, 6 and 7 stay reserved
    m[`TRAP_OSC_FAIL] = 1'b1;
    m[`TRAP_ADDR_ERR] = 1'b1;
    m[`TRAP_STACK_ERR] = 1'b1;
    m[`TRAP_MATH_ERR] = 1'b1;
    // Request 4, requests 14 and 15 and the gaps stay reserved
    m[`NUM_TRAP + `IRQ_EXT0] = 1'b1;
    m[`NUM_TRAP + `IRQ_CAP1] = 1'b1;
    m[`NUM_TRAP + `IRQ_CMP1] = 1'b1;
    m[`NUM_TRAP + `IRQ_TMR1] = 1'b1;
    m[`NUM_TRAP + `IRQ_CAP2] = 1'b1;
    m[`NUM_TRAP + `IRQ_CMP2] = 1'b1;
    m[`NUM_TRAP + `IRQ_TMR2] = 1'b1;
    m[`NUM_TRAP + `IRQ_TMR3] = 1'b1;
    m[`NUM_TRAP + `IRQ_SPI_ERR] = 1'b1;
    m[`NUM_TRAP + `IRQ_SPI_DONE] = 1'b1;
    m[`NUM_TRAP + `IRQ_UART_RX] = 1'b1;
    m[`NUM_TRAP + `IRQ_UART_TX] = 1'b1;
    m[`NUM_TRAP + `IRQ_ADC] = 1'b1;
    m[`NUM_TRAP + `IRQ_I2C_SLV] = 1'b1;
    m[`NUM_TRAP + `IRQ_I2C_MST] = 1'b1;
    m[`NUM_TRAP + `IRQ_COMPARATOR] = 1'b1;
    m[`NUM_TRAP + `IRQ_CHANGE_NOTIFY] = 1'b1;
    m[`NUM_TRAP + `IRQ_EXT1] = 1'b1;
    m[`NUM_TRAP + `IRQ_TMR4] = has_t45;
    m[`NUM_TRAP + `IRQ_TMR5] = has_t45;
    m[`NUM_TRAP + `IRQ_EXT2] = 1'b1;
    m[`NUM_TRAP + `IRQ_CAP3] = 1'b1;
    m[`NUM_TRAP + `IRQ_PWM_PERIOD] = 1'b1;
    m[`NUM_TRAP + `IRQ_CALENDAR] = 1'b1;
    m[`NUM_TRAP + `IRQ_FAULT_A] = 1'b1;
    m[`NUM_TRAP + `IRQ_FAULT_B] = has_fb;
    m[`NUM_TRAP + `IRQ_UART_ERR] = 1'b1;
    m[`NUM_TRAP + `IRQ_CHARGE_TIME] = 1'b1;
    return m;
  endfunction : impl_mask

  localparam logic [`NUM_VEC-1:0] IMPL_MASK = impl_mask(HAS_TIMER45, HAS_FAULT_B);

  // Only implemented traps reach the encoder
  always_comb begin
    trap_req = '0;
    trap_req[`TRAP_OSC_FAIL] = trap_osc_fail; // R05
    trap_req[`TRAP_ADDR_ERR] = trap_addr_err; // R05
    trap_req[`TRAP_STACK_ERR] = trap_stack_err; // R05
    trap_req[`TRAP_MATH_ERR] = trap_math_err; // R05
  end

  // Reserved positions stay zero
  always_comb begin
    irq_req = '0; // R15
    irq_req[`IRQ_EXT0] = external_irq_zero; // R07
    irq_req[`IRQ_CAP1] = capture_unit_one; // R07
    irq_req[`IRQ_CMP1] = compare_unit_one; // R07
    irq_req[`IRQ_TMR1] = timer_one; // R07
    irq_req[`IRQ_CAP2] = capture_unit_two; // R07
    irq_req[`IRQ_CMP2] = compare_unit_two; // R07
    irq_req[`IRQ_TMR2] = timer_two; // R07
    irq_req[`IRQ_TMR3] = timer_three; // R07
    irq_req[`IRQ_SPI_ERR] = spi_error_source; // R08
    irq_req[`IRQ_SPI_DONE] = spi_done_source; // R08
    irq_req[`IRQ_UART_RX] = uart_receive_source; // R08
    irq_req[`IRQ_UART_TX] = uart_transmit_source; // R08
    irq_req[`IRQ_ADC] = converter_source; // R08
    irq_req[`IRQ_I2C_SLV] = i2c_slave_source; // R08
    irq_req[`IRQ_I2C_MST] = i2c_master_source; // R08
    irq_req[`IRQ_UART_ERR] = uart_error_source; // R08
    irq_req[`IRQ_COMPARATOR] = comparator_source; // R09
    irq_req[`IRQ_CHANGE_NOTIFY] = change_notify_source; // R09
    irq_req[`IRQ_EXT1] = external_irq_one; // R09
    irq_req[`IRQ_TMR4] = timer_four & HAS_TIMER45; // R10
    irq_req[`IRQ_TMR5] = timer_five & HAS_TIMER45; // R10
    irq_req[`IRQ_EXT2] = external_irq_two; // R09
    irq_req[`IRQ_CAP3] = capture_unit_three; // R09
    irq_req[`IRQ_PWM_PERIOD] = pwm_period_source; // R09
    irq_req[`IRQ_CALENDAR] = calendar_clock_source; // R09
    irq_req[`IRQ_FAULT_A] = pwm_fault_a_source; // R09
    irq_req[`IRQ_FAULT_B] = pwm_fault_b_source & HAS_FAULT_B; // R10
    irq_req[`IRQ_CHARGE_TIME] = charge_time_source; // R09
  end

  // Request n lands at vector n plus eight
  assign all_req = {irq_req, trap_req} & IMPL_MASK; // R06 R15

  // Scan from the top so the lowest pending vector is kept
  always_comb begin
    winner = '0;
    winner_any = 1'b0;
    for (int i = `NUM_VEC - 1; i >= 0; i--) begin
      if (all_req[i]) begin
        winner.vec_num = 7'(i); // R14
        winner.is_trap = (i < `NUM_TRAP);
        winner_any = 1'b1;
      end
    end
  end

  // A take only counts while a registered vector is on offer
  assign accept = (state_ff == ST_IDLE) && vec_pending_ff && take_vec;

  // Entry address from vector number and table choice
  always_comb begin
    nxt_taken.alt = alt_table_select; // R01
    nxt_taken.is_trap = pend_trap_ff;
    nxt_taken.vec_num = pend_num_ff;
    nxt_fetch_addr = `TABLE_BASE + {16'h0000, pend_num_ff, 1'b0}; // R05 R06
    if (alt_table_select) begin
      nxt_fetch_addr = nxt_fetch_addr + `ALT_OFFSET; // R01 R02
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET_ENTRY: begin
        nxt_state = ST_IDLE; // R03
      end
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fetch_valid) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Reset lands in the entry state so the zero load happens once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_RESET_ENTRY; // R04
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pending request toward the CPU, held off while busy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vec_pending_ff <= 1'b0;
      pend_num_ff <= 7'h00;
      pend_trap_ff <= 1'b0;
    end else if (nxt_state == ST_IDLE && !accept) begin
      vec_pending_ff <= winner_any; // R15
      pend_num_ff <= winner.vec_num; // R14
      pend_trap_ff <= winner.is_trap;
    end else begin
      vec_pending_ff <= 1'b0;
    end
  end

  // Entry read toward program memory
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetch_req_ff <= 1'b0;
      fetch_addr_ff <= `RESET_ADDR;
    end else if (accept) begin
      fetch_req_ff <= 1'b1;
      fetch_addr_ff <= nxt_fetch_addr; // R01 R02
    end else if (state_ff == ST_FETCH && fetch_valid) begin
      fetch_req_ff <= 1'b0;
    end
  end

  // Program counter load: zero after reset, handler address after fetch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_load_ff <= 1'b0;
      pc_value_ff <= `RESET_ADDR; // R04
    end else if (state_ff == ST_RESET_ENTRY) begin
      pc_load_ff <= 1'b1; // R03 R04
      pc_value_ff <= `RESET_ADDR; // R04
    end else if (state_ff == ST_FETCH && fetch_valid) begin
      pc_load_ff <= 1'b1;
      pc_value_ff <= fetch_data; // R13
    end else begin
      pc_load_ff <= 1'b0;
    end
  end

  // Taken vector report, latched when the CPU takes the vector
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      taken_ff <= '0;
    end else if (accept) begin
      taken_ff <= nxt_taken;
    end
  end

  // Flag logic may clear the source on this pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      taken_valid_ff <= 1'b0;
    end else begin
      taken_valid_ff <= (state_ff == ST_FETCH) && fetch_valid;
    end
  end

  // Busy is set in reset so nothing is offered before the zero load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b1;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

endmodule : vector_select

/* shared/vector_select_cfg.svh */
`ifndef VECTOR_SELECT_CFG_SVH
`define VECTOR_SELECT_CFG_SVH

// Table layout
`define RESET_ADDR 24'h000000
`define TABLE_BASE 24'h000004
`define ALT_OFFSET 24'h000100
`define NUM_VEC 126
`define NUM_TRAP 8
`define NUM_IRQ 118
`define IRQ_VEC_OFFSET 7'h08

// Trap vector numbers
`define TRAP_OSC_FAIL 1
`define TRAP_ADDR_ERR 2
`define TRAP_STACK_ERR 3
`define TRAP_MATH_ERR 4

// Request numbers
`define IRQ_EXT0 0
`define IRQ_CAP1 1
`define IRQ_CMP1 2
`define IRQ_TMR1 3
`define IRQ_CAP2 5
`define IRQ_CMP2 6
`define IRQ_TMR2 7
`define IRQ_TMR3 8
`define IRQ_SPI_ERR 9
`define IRQ_SPI_DONE 10
`define IRQ_UART_RX 11
`define IRQ_UART_TX 12
`define IRQ_ADC 13
`define IRQ_I2C_SLV 16
`define IRQ_I2C_MST 17
`define IRQ_COMPARATOR 18
`define IRQ_CHANGE_NOTIFY 19
`define IRQ_EXT1 20
`define IRQ_TMR4 27
`define IRQ_TMR5 28
`define IRQ_EXT2 29
`define IRQ_CAP3 37
`define IRQ_PWM_PERIOD 57
`define IRQ_CALENDAR 62
`define IRQ_FAULT_A 63
`define IRQ_FAULT_B 64
`define IRQ_UART_ERR 65
`define IRQ_CHARGE_TIME 77

`endif

/* shared/vector_select_pkg.sv */
package vector_select_pkg;

  typedef enum logic [1:0] {
    ST_RESET_ENTRY = 2'b00,
    ST_IDLE = 2'b01,
    ST_FETCH = 2'b10
  } vsel_state_t;

  typedef struct packed {
    logic is_trap;
    logic [6:0] vec_num;
  } vec_choice_t;

  typedef struct packed {
    logic alt;
    logic is_trap;
    logic [6:0] vec_num;
  } vec_taken_t;

endpackage : vector_select_pkg

/* test/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic vec_pending_ff, // Pending
  input wire logic fetch_req_ff, // Fetch
  input wire logic [23:0] fetch_addr_ff, // Entry
  input wire logic [3:0] dly, // Memory wait
  output logic take_vec, // Take
  output logic fetch_valid, // Word valid
  output logic [23:0] fetch_data // Word
);
  // Default handler address is arbitrary
  localparam logic [23:0] DEF_HANDLER = 24'h000200;
  logic [3:0] cnt;
  logic [23:0] word;
  logic used;
  initial begin
    take_vec = 1'b0;
    fetch_valid = 1'b0;
    fetch_data = 24'h0;
    cnt = 4'h0;
    forever begin
      @(posedge clk);
      #1;
      cnt = fetch_req_ff ? cnt + 4'h1 : 4'h0;
      used = 7'((fetch_addr_ff[7:0] - 8'h04) >> 1) inside
        {[1:4], [8:11], [13:21], [24:28], [35:37], 45, 65, [70:73], 85};
      // Both tables hold the same handler; unused entries lead to a reset handler
      word = used ? {fetch_addr_ff[23:9], 1'b0, fetch_addr_ff[7:0]} ^ 24'ha50000 :
        DEF_HANDLER;
      fetch_valid = fetch_req_ff && cnt > dly;
      take_vec = resetn && vec_pending_ff && !fetch_req_ff;
      // Word is meaningless outside a valid beat
      fetch_data = fetch_valid ? word : ~fetch_data;
    end
  end
endmodule : cpu_model

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import vector_select_pkg::*;
  logic clk, resetn, alt_table_select, take_vec, fetch_valid, vec_pending_ff, pend_trap_ff;
  logic fetch_req_ff, pc_load_ff, taken_valid_ff, busy_ff;
  logic [23:0] fetch_data, fetch_addr_ff, pc_value_ff;
  logic [6:0] pend_num_ff, sm_num;
  logic sm_pend;
  logic [31:0] s;
  logic [3:0] dly;
  vec_taken_t taken_ff;
  int error_cnt, checked, w;
  localparam int VN[32] = '{1, 2, 3, 4, 8, 9, 10, 11, 13, 14, 15, 16, 17, 18, 19, 20,
    21, 24, 25, 26, 27, 28, 35, 36, 37, 45, 65, 70, 71, 72, 73, 85};
  vector_select dut_u (.clk(clk), .resetn(resetn), .alt_table_select(alt_table_select),
    .trap_osc_fail(s[0]), .trap_addr_err(s[1]), .trap_stack_err(s[2]),
    .trap_math_err(s[3]), .external_irq_zero(s[4]), .capture_unit_one(s[5]),
    .compare_unit_one(s[6]), .timer_one(s[7]), .capture_unit_two(s[8]),
    .compare_unit_two(s[9]), .timer_two(s[10]), .timer_three(s[11]), .spi_error_source(s[12]),
    .spi_done_source(s[13]), .uart_receive_source(s[14]), .uart_transmit_source(s[15]),
    .converter_source(s[16]), .i2c_slave_source(s[17]), .i2c_master_source(s[18]),
    .comparator_source(s[19]), .change_notify_source(s[20]), .external_irq_one(s[21]),
    .timer_four(s[22]), .timer_five(s[23]), .external_irq_two(s[24]),
    .capture_unit_three(s[25]), .pwm_period_source(s[26]), .calendar_clock_source(s[27]),
    .pwm_fault_a_source(s[28]), .pwm_fault_b_source(s[29]), .uart_error_source(s[30]),
    .charge_time_source(s[31]), .take_vec(take_vec), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .vec_pending_ff(vec_pending_ff), .pend_num_ff(pend_num_ff),
    .pend_trap_ff(pend_trap_ff), .fetch_req_ff(fetch_req_ff), .fetch_addr_ff(fetch_addr_ff),
    .pc_load_ff(pc_load_ff), .pc_value_ff(pc_value_ff), .taken_valid_ff(taken_valid_ff),
    .taken_ff(taken_ff), .busy_ff(busy_ff));
  // Smallest build: timers four and five and fault B are absent
  vector_select #(.HAS_TIMER45(1'b0), .HAS_FAULT_B(1'b0)) dut_small_u (.clk(clk),
    .resetn(resetn), .alt_table_select(alt_table_select),
    .trap_osc_fail(s[0]), .trap_addr_err(s[1]), .trap_stack_err(s[2]),
    .trap_math_err(s[3]), .external_irq_zero(s[4]), .capture_unit_one(s[5]),
    .compare_unit_one(s[6]), .timer_one(s[7]), .capture_unit_two(s[8]),
    .compare_unit_two(s[9]), .timer_two(s[10]), .timer_three(s[11]), .spi_error_source(s[12]),
    .spi_done_source(s[13]), .uart_receive_source(s[14]), .uart_transmit_source(s[15]),
    .converter_source(s[16]), .i2c_slave_source(s[17]), .i2c_master_source(s[18]),
    .comparator_source(s[19]), .change_notify_source(s[20]), .external_irq_one(s[21]),
    .timer_four(s[22]), .timer_five(s[23]), .external_irq_two(s[24]),
    .capture_unit_three(s[25]), .pwm_period_source(s[26]), .calendar_clock_source(s[27]),
    .pwm_fault_a_source(s[28]), .pwm_fault_b_source(s[29]), .uart_error_source(s[30]),
    .charge_time_source(s[31]), .take_vec(1'b0), .fetch_valid(1'b0),
    .fetch_data(24'h000000), .vec_pending_ff(sm_pend), .pend_num_ff(sm_num),
    .pend_trap_ff(), .fetch_req_ff(), .fetch_addr_ff(), .pc_load_ff(), .pc_value_ff(),
    .taken_valid_ff(), .taken_ff(), .busy_ff());
  cpu_model cpu_u (.clk(clk), .resetn(resetn), .vec_pending_ff(vec_pending_ff),
    .fetch_req_ff(fetch_req_ff), .fetch_addr_ff(fetch_addr_ff), .dly(dly),
    .take_vec(take_vec), .fetch_valid(fetch_valid), .fetch_data(fetch_data));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task test_done;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  function int win(logic [31:0] v);
    for (int i = 0; i < 32; i++) if (v[i]) return VN[i];
    return -1;
  endfunction : win
  task tick;
    @(posedge clk);
    #1;
  endtask : tick
  task run1(logic [31:0] v, bit al);
    int t;
    logic [31:0] vm;
    tick;
    s = v;
    alt_table_select = al;
    dly = 4'($urandom_range(5, 0));
    w = win(v);
    t = 0;
    while (fetch_req_ff !== 1'b1 && t < 100) begin tick; t++; end
    chk("entry", 24'h4 + 2 * w + (al ? 24'h100 : 24'h0), 32'(fetch_addr_ff));
    // Small build never offers timers four and five or fault B
    vm = v & ~32'h20c00000;
    chk("small", (vm != 32'h0) ? (32'h80 | 32'(win(vm))) : 32'h0, 32'({sm_pend, sm_num}));
    // Table choice must be latched at take
    s = 32'h0;
    alt_table_select = ~al;
    while (taken_valid_ff !== 1'b1 && t < 100) begin tick; t++; end
    chk("taken", {al, w < 8, 7'(w)}, 32'(taken_ff));
    chk("pc", (24'h4 + 2 * w) ^ 24'ha50000, 32'(pc_value_ff));
    chk("wait", 32'h0, 32'(t > 99));
  endtask : run1
  task do_reset;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    chk("req", 32'h0, 32'(fetch_req_ff));
    #1 resetn = 1'b1;
    tick;
    chk("load", 32'h1, 32'(pc_load_ff));
    chk("zero", 32'h0, 32'(pc_value_ff));
    chk("vect", 32'h0, 32'(taken_valid_ff));
  endtask : do_reset
  initial begin
    resetn = 1'b0;
    s = 32'h0;
    alt_table_select = 1'b0;
    dly = 4'h0;
    error_cnt = 0;
    checked = 0;
    void'($urandom(32'h6bc9));
    do_reset;
    repeat (4) tick;
    chk("idle", 32'h0, 32'(vec_pending_ff));
    for (int i = 0; i < 32; i++) run1(32'h1 << i, 1'($urandom));
    repeat (40) run1($urandom | (32'h1 << $urandom_range(31, 0)), 1'($urandom));
    // Reset in mid fetch must restart at zero
    tick;
    s = 32'h10;
    dly = 4'hf;
    repeat (4) tick;
    chk("mid", 32'h1, 32'(fetch_req_ff));
    s = 32'h0;
    do_reset;
    test_done;
  end
  initial begin
    #100000;
    error_cnt++;
    test_done;
  end
endmodule : testbench

/* test/vector_select_props.sv */
`timescale 1ns/1ps
module vector_select_props
  import vector_select_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic take_vec, // Take
  input wire logic fetch_valid, // Word valid
  input wire logic [23:0] fetch_data, // Word
  input wire logic alt_table_select, // Table
  input wire logic vec_pending_ff, // Pending
  input wire logic [6:0] pend_num_ff, // Winner
  input wire logic pend_trap_ff, // Trap
  input wire logic fetch_req_ff, // Fetch
  input wire logic [23:0] fetch_addr_ff, // Entry
  input wire logic pc_load_ff, // PC load
  input wire logic [23:0] pc_value_ff, // PC
  input wire logic taken_valid_ff, // Taken
  input wire logic busy_ff // Busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_entry_addr: assert property (take_vec && vec_pending_ff |=> fetch_req_ff &&
    fetch_addr_ff == 24'h4 + {$past(pend_num_ff), 1'b0} + ($past(alt_table_select) ? 24'h100 : 24'h0))
    else $error("entry address wrong");
  a_pc_handler: assert property (fetch_valid && fetch_req_ff |=> pc_load_ff &&
    taken_valid_ff && pc_value_ff == $past(fetch_data)) else $error("handler load wrong");
  a_reset_zero: assert property (pc_load_ff && !taken_valid_ff |->
    pc_value_ff == 24'h0 && !fetch_req_ff) else $error("reset entry wrong");
  a_trap_kind: assert property (vec_pending_ff |->
    pend_trap_ff == (pend_num_ff < 7'h08)) else $error("trap flag wrong");
  a_no_reserved: assert property (vec_pending_ff |-> pend_num_ff inside
    {[1:4], [8:11], [13:21], [24:28], [35:37], 45, 65, [70:73], 85}) else $error("reserved vector");
  a_pulse_single: assert property (pc_load_ff |=> !pc_load_ff) else $error("load held");
  a_busy_quiet: assert property (busy_ff |-> !vec_pending_ff && !pc_load_ff)
    else $error("pending while busy");
  a_fetch_hold: assert property (fetch_req_ff && !fetch_valid |=>
    fetch_req_ff && $stable(fetch_addr_ff)) else $error("fetch dropped");
  c_alt: cover property (take_vec && vec_pending_ff && alt_table_select);
  c_trap: cover property (take_vec && vec_pending_ff && pend_trap_ff);
  c_reset: cover property (pc_load_ff && !taken_valid_ff);
endmodule : vector_select_props

bind vector_select vector_select_props p_u (.clk(clk), .resetn(resetn), .take_vec(take_vec),
  .fetch_valid(fetch_valid), .fetch_data(fetch_data), .alt_table_select(alt_table_select),
  .vec_pending_ff(vec_pending_ff), .pend_num_ff(pend_num_ff), .pend_trap_ff(pend_trap_ff),
  .fetch_req_ff(fetch_req_ff), .fetch_addr_ff(fetch_addr_ff), .pc_load_ff(pc_load_ff),
  .pc_value_ff(pc_value_ff), .taken_valid_ff(taken_valid_ff), .busy_ff(busy_ff));
